// [mts_link_params.svh]
`ifndef MTS_LINK_PARAMS_SVH
`define MTS_LINK_PARAMS_SVH

`define DEV_ADDR       7'h47
`define NUM_SETTINGS   7
`define FIRST_SUBADDR  8'h00
`define MUTE_REG       6
`define MUTE_BIT       0
`define SETTING_RST    8'h00
`define MUTE_RST       1'b0
`define STAT_LOW_BITS  2'h3
`define REF_CLK_KHZ    20000
`define SCL_MAX_KHZ    100
`define QUARTER_CYC    ((`REF_CLK_KHZ + 4 * `SCL_MAX_KHZ - 1) / (4 * `SCL_MAX_KHZ))
`define OFS_CTRL       5'h00
`define OFS_SUBADDR    5'h04
`define OFS_WDATA      5'h08
`define OFS_RDATA      5'h0c
`define OFS_STATUS     5'h10
`define OFS_IRQ_STAT   5'h14
`define OFS_IRQ_MASK   5'h18
`define CTRL_GO_BIT    0
`define CTRL_RD_BIT    1
`define IRQ_DONE_BIT   0
`define IRQ_NACK_BIT   1

`endif

// [mts_link_pkg.sv]
package mts_link_pkg;
  typedef enum logic [4:0] {
    d_idle  = 5'h01,
    d_addr  = 5'h02,
    d_sub   = 5'h04,
    d_wdata = 5'h08,
    d_read  = 5'h10
  } dev_state_t;

  typedef enum logic [3:0] {
    h_idle  = 4'h1,
    h_start = 4'h2,
    h_bit   = 4'h4,
    h_stop  = 4'h8
  } host_state_t;
endpackage

// [mts_link_if.sv]
`timescale 1ns/1ps
interface mts_link_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups
  assign scl = m_scl_oe_n | m_scl_o;
  assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

  modport host (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
  modport device (output s_sda_o, s_sda_oe_n, input scl, sda);
endinterface

// [mts_link_dev.sv]
`timescale 1ns/1ps
`include "mts_link_params.svh"
module mts_link_dev (
  mts_link_if.device       link,          // Two-wire bus, device end
  input  wire logic        ref_clk,       // 20 MHz clock
  input  wire logic        nrst,          // Async reset, active low
  input  wire logic        pilot_det,     // Stereo pilot present
  input  wire logic        sap_det,       // SAP carrier present
  input  wire logic        noise_det,     // Noise detected
  input  wire logic        stereo_rx,     // Stereo reception
  input  wire logic        sap_rx,        // SAP reception
  output logic [55:0]      settings,      // Setting registers, reg 0 low
  output logic             wr_pulse,      // One-cycle store strobe
  output logic [2:0]       wr_index       // Register just stored
);
  mts_link_pkg::dev_state_t st, next_st;
  logic [1:0] scl_m, sda_m;
  logic       scl_s, sda_s, scl_d, sda_d;
  logic [4:0] det_m, det_s;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic       in_ack, next_in_ack;
  logic [7:0] shreg, next_shreg;
  logic [7:0] ptr, next_ptr;
  logic       sda_low, next_sda_low;
  logic       por, next_por;
  logic [7:0] regs [0:`NUM_SETTINGS-1];
  logic [7:0] next_regs [0:`NUM_SETTINGS-1];
  logic       next_wr_pulse;
  logic [2:0] next_wr_index;
  logic       scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] status;

  // Bus pins and detector levels are asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_m <= 2'h3;
      sda_m <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      det_m <= 5'h00;
      det_s <= 5'h00;
    end
    else
    begin
      scl_m <= {scl_m[0], link.scl};
      sda_m <= {sda_m[0], link.sda};
      scl_d <= scl_s;
      sda_d <= sda_s;
      det_m <= {pilot_det, sap_det, noise_det, stereo_rx, sap_rx};
      det_s <= det_m;
    end
  end

  assign scl_s = scl_m[1];
  assign sda_s = sda_m[1];

  // Edge and condition detection on synchronised lines
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;
  assign status     = {por, det_s, `STAT_LOW_BITS};

  // Protocol engine and register file
  always_comb
  begin
    next_st       = st;
    next_bit_cnt  = bit_cnt;
    next_in_ack   = in_ack;
    next_shreg    = shreg;
    next_ptr      = ptr;
    next_sda_low  = sda_low;
    next_por      = por;
    next_regs     = regs;
    next_wr_pulse = 1'b0;
    next_wr_index = wr_index;
    if (start_seen)
    begin
      next_st      = mts_link_pkg::d_addr;
      next_bit_cnt = 4'h0;
      next_in_ack  = 1'b0;
      next_sda_low = 1'b0;
    end
    else if (stop_seen)
    begin
      next_st      = mts_link_pkg::d_idle;
      next_in_ack  = 1'b0;
      next_sda_low = 1'b0;
    end
    else if (st != mts_link_pkg::d_idle)
    begin
      // Sample while SCL high; data is stable then
      if (scl_rise && bit_cnt < 4'h8)
      begin
        next_bit_cnt = bit_cnt + 4'h1;
        if (st != mts_link_pkg::d_read)
          next_shreg = {shreg[6:0], sda_s};
      end
      else if (scl_rise && in_ack && st == mts_link_pkg::d_read && sda_s)
      begin
        next_st      = mts_link_pkg::d_idle;
        next_sda_low = 1'b0;
        next_in_ack  = 1'b0;
      end
      else if (scl_fall && in_ack)
      begin
        // Leaving the acknowledge slot
        next_in_ack  = 1'b0;
        next_bit_cnt = 4'h0;
        next_sda_low = 1'b0;
        case (st)
          mts_link_pkg::d_addr:
          begin
            if (shreg[0])
            begin
              next_st      = mts_link_pkg::d_read;
              next_shreg   = status;
              next_sda_low = ~status[7];
              next_por     = 1'b0;
            end
            else
              next_st = mts_link_pkg::d_sub;
          end
          mts_link_pkg::d_sub:
            next_st = mts_link_pkg::d_wdata;
          mts_link_pkg::d_read:
          begin
            // Master acked: send the status again
            next_shreg   = status;
            next_sda_low = ~status[7];
          end
          default:
            next_sda_low = 1'b0;
        endcase
      end
      else if (scl_fall && bit_cnt == 4'h8)
      begin
        // Entering the acknowledge slot
        next_in_ack = 1'b1;
        case (st)
          mts_link_pkg::d_addr:
          begin
            if (shreg[7:1] == `DEV_ADDR)
              next_sda_low = 1'b1;
            else
            begin
              next_st = mts_link_pkg::d_idle;
              next_in_ack = 1'b0;
            end
          end
          mts_link_pkg::d_sub:
          begin
            next_ptr     = shreg;
            next_sda_low = 1'b1;
          end
          mts_link_pkg::d_wdata:
          begin
            // Bytes past the last register are refused
            if (ptr < 8'(`NUM_SETTINGS))
            begin
              next_regs[ptr[2:0]] = shreg;
              next_wr_pulse       = 1'b1;
              next_wr_index       = ptr[2:0];
              next_ptr            = ptr + 8'h01;
              next_sda_low        = 1'b1;
            end
          end
          default:
            next_sda_low = 1'b0; // Master owns the slot on read
        endcase
      end
      else if (scl_fall && st == mts_link_pkg::d_read)
      begin
        next_shreg   = {shreg[6:0], 1'b0};
        next_sda_low = ~shreg[6];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st       <= mts_link_pkg::d_idle;
      bit_cnt  <= 4'h0;
      in_ack   <= 1'b0;
      shreg    <= 8'h00;
      ptr      <= `FIRST_SUBADDR;
      sda_low  <= 1'b0;
      por      <= 1'b1;
      wr_pulse <= 1'b0;
      wr_index <= 3'h0;
      for (int i = 0; i < `NUM_SETTINGS; i++)
        regs[i] <= `SETTING_RST;
      regs[`MUTE_REG][`MUTE_BIT] <= `MUTE_RST;
    end
    else
    begin
      st       <= next_st;
      bit_cnt  <= next_bit_cnt;
      in_ack   <= next_in_ack;
      shreg    <= next_shreg;
      ptr      <= next_ptr;
      sda_low  <= next_sda_low;
      por      <= next_por;
      wr_pulse <= next_wr_pulse;
      wr_index <= next_wr_index;
      regs     <= next_regs;
    end
  end

  // Flatten register file onto the user port
  genvar g;
  generate
    for (g = 0; g < `NUM_SETTINGS; g++)
    begin : g_out
      assign settings[g*8 +: 8] = regs[g];
    end
  endgenerate

  // Open drain: only ever pull low
  assign link.s_sda_o    = 1'b0;
  assign link.s_sda_oe_n = ~sda_low;
endmodule // mts_link_dev

// [mts_link_host.sv]
`timescale 1ns/1ps
`include "mts_link_params.svh"
module mts_link_host #(
  parameter int QUARTER = `QUARTER_CYC   // Cycles per quarter SCL period
) (
  mts_link_if.host         link,          // Two-wire bus, master end
  input  wire logic        ref_clk,       // 20 MHz clock
  input  wire logic        nrst,          // Async reset, active low
  input  wire logic [4:0]  avs_address,   // Byte address
  input  wire logic        avs_read,      // Read request
  input  wire logic        avs_write,     // Write request
  input  wire logic [31:0] avs_writedata, // Write data
  output logic [31:0]      avs_readdata,  // Read data
  output logic             avs_waitrequest, // Stall, high by default
  output logic             irq            // Level interrupt
);
  // Shorter quarters break the clock limit; the counter is 8 bits
  if (QUARTER < `QUARTER_CYC || QUARTER > 255)
  begin : g_bad_quarter
    $error("QUARTER out of range");
  end

  mts_link_pkg::host_state_t hst, next_hst;
  logic [7:0] qcnt, next_qcnt;
  logic [1:0] q, next_q, byte_i, next_byte_i;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] txsh, next_txsh, rxsh, next_rxsh;
  logic [7:0] sub, next_sub, wdata, next_wdata, rdata, next_rdata;
  logic       rw, next_rw, nack, next_nack, busy, next_busy;
  logic       scl_low, next_scl_low, sda_low, next_sda_low;
  logic [1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, irq_set;
  logic       next_irq, next_wreq;
  logic [31:0] next_rd;
  logic [1:0] sda_m;
  logic       tick, take, rx_byte;

  // Returned data line is asynchronous to this end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      sda_m <= 2'h3;
    else
      sda_m <= {sda_m[0], link.sda};
  end

  // Quarter-period enable keeps SCL at or below the limit
  assign tick    = (qcnt == 8'(QUARTER - 1));
  assign take    = (avs_read | avs_write) & ~avs_waitrequest;
  assign rx_byte = rw & (byte_i == 2'h1);

  always_comb
  begin
    next_hst      = hst;
    next_qcnt     = tick ? 8'h00 : qcnt + 8'h01;
    next_q        = q;
    next_byte_i   = byte_i;
    next_bit_cnt  = bit_cnt;
    next_txsh     = txsh;
    next_rxsh     = rxsh;
    next_sub      = sub;
    next_wdata    = wdata;
    next_rdata    = rdata;
    next_rw       = rw;
    next_nack     = nack;
    next_busy     = busy;
    next_scl_low  = scl_low;
    next_sda_low  = sda_low;
    next_irq_mask = irq_mask;
    irq_set       = 2'h0;
    // Bus slave: one wait cycle, then answer
    next_wreq = ~((avs_read | avs_write) & avs_waitrequest);
    next_rd   = 32'h0000_0000;
    case (avs_address)
      `OFS_SUBADDR:  next_rd = {24'h0, sub};
      `OFS_WDATA:    next_rd = {24'h0, wdata};
      `OFS_RDATA:    next_rd = {24'h0, rdata};
      `OFS_STATUS:   next_rd = {30'h0, nack, busy};
      `OFS_IRQ_STAT: next_rd = {30'h0, irq_stat};
      `OFS_IRQ_MASK: next_rd = {30'h0, irq_mask};
      default:       next_rd = 32'h0000_0000;
    endcase
    if (take && avs_write)
    begin
      case (avs_address)
        `OFS_SUBADDR:  next_sub = avs_writedata[7:0];
        `OFS_WDATA:    next_wdata = avs_writedata[7:0];
        `OFS_IRQ_MASK: next_irq_mask = avs_writedata[1:0];
        default:       next_wreq = next_wreq;
      endcase
    end
    // A start request while busy is dropped
    if (take && avs_write && avs_address == `OFS_CTRL && avs_writedata[`CTRL_GO_BIT] && !busy)
    begin
      next_hst  = mts_link_pkg::h_start;
      next_rw   = avs_writedata[`CTRL_RD_BIT];
      next_busy = 1'b1;
      next_nack = 1'b0;
      next_q    = 2'h0;
      next_qcnt = 8'h00;
    end
    else if (tick && hst != mts_link_pkg::h_idle)
    begin
      next_q = q + 2'h1;
      case (hst)
        mts_link_pkg::h_start:
        begin
          if (q == 2'h1)
            next_sda_low = 1'b1;
          if (q == 2'h3)
          begin
            next_scl_low = 1'b1;
            next_hst     = mts_link_pkg::h_bit;
            next_bit_cnt = 4'h0;
            next_byte_i  = 2'h0;
            next_txsh    = {`DEV_ADDR, rw};
          end
        end
        mts_link_pkg::h_bit:
        begin
          case (q)
            2'h0: next_sda_low = (bit_cnt < 4'h8) & ~rx_byte & ~txsh[7];
            2'h1: next_scl_low = 1'b0;
            2'h2:
            begin
              if (bit_cnt < 4'h8)
              begin
                next_rxsh = {rxsh[6:0], sda_m[1]};
                next_txsh = {txsh[6:0], 1'b0};
              end
              else if (!rx_byte && sda_m[1])
                next_nack = 1'b1;
            end
            default:
            begin
              next_scl_low = 1'b1;
              next_bit_cnt = bit_cnt + 4'h1;
              if (bit_cnt == 4'h8)
              begin
                next_bit_cnt = 4'h0;
                next_byte_i  = byte_i + 2'h1;
                next_txsh    = (byte_i == 2'h0) ? sub : wdata;
                if (rx_byte)
                  next_rdata = rxsh;
                if (nack || rx_byte || byte_i == 2'h2)
                  next_hst = mts_link_pkg::h_stop;
              end
            end
          endcase
        end
        mts_link_pkg::h_stop:
        begin
          case (q)
            2'h0: next_sda_low = 1'b1;
            2'h1: next_scl_low = 1'b0;
            2'h2: next_sda_low = 1'b0;
            default:
            begin
              next_hst  = mts_link_pkg::h_idle;
              next_busy = 1'b0;
              irq_set   = {nack, 1'b1};
            end
          endcase
        end
        default:
          next_hst = mts_link_pkg::h_idle;
      endcase
    end
    // Write one to clear; a new event wins over the clear
    next_irq_stat = irq_stat;
    if (take && avs_write && avs_address == `OFS_IRQ_STAT)
      next_irq_stat = irq_stat & ~avs_writedata[1:0];
    next_irq_stat = next_irq_stat | irq_set;
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hst             <= mts_link_pkg::h_idle;
      qcnt            <= 8'h00;
      q               <= 2'h0;
      byte_i          <= 2'h0;
      bit_cnt         <= 4'h0;
      txsh            <= 8'h00;
      rxsh            <= 8'h00;
      sub             <= `FIRST_SUBADDR;
      wdata           <= 8'h00;
      rdata           <= 8'h00;
      rw              <= 1'b0;
      nack            <= 1'b0;
      busy            <= 1'b0;
      scl_low         <= 1'b0;
      sda_low         <= 1'b0;
      irq_stat        <= 2'h0;
      irq_mask        <= 2'h0;
      irq             <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      hst             <= next_hst;
      qcnt            <= next_qcnt;
      q               <= next_q;
      byte_i          <= next_byte_i;
      bit_cnt         <= next_bit_cnt;
      txsh            <= next_txsh;
      rxsh            <= next_rxsh;
      sub             <= next_sub;
      wdata           <= next_wdata;
      rdata           <= next_rdata;
      rw              <= next_rw;
      nack            <= next_nack;
      busy            <= next_busy;
      scl_low         <= next_scl_low;
      sda_low         <= next_sda_low;
      irq_stat        <= next_irq_stat;
      irq_mask        <= next_irq_mask;
      irq             <= next_irq;
      avs_waitrequest <= next_wreq;
      avs_readdata    <= next_rd;
    end
  end

  // Open-drain pins: low level only, enable low while pulling
  assign link.m_scl_o    = 1'b0;
  assign link.m_scl_oe_n = ~scl_low;
  assign link.m_sda_o    = 1'b0;
  assign link.m_sda_oe_n = ~sda_low;
endmodule // mts_link_host

// [mts_link_sva.sv]
`timescale 1ns/1ps
`include "mts_link_params.svh"
module mts_link_sva #(
  parameter int QUARTER = 50    // Cycles per quarter SCL period
) (
  input wire logic ref_clk,     // Clock
  input wire logic nrst,        // Reset, active low
  input wire logic m_scl_o,     // Host SCL level
  input wire logic m_scl_oe_n,  // Host SCL enable
  input wire logic m_sda_o,     // Host SDA level
  input wire logic m_sda_oe_n,  // Host SDA enable
  input wire logic s_sda_o,     // Device SDA level
  input wire logic s_sda_oe_n,  // Device SDA enable
  input wire logic scl,         // Resolved SCL
  input wire logic sda          // Resolved SDA
);
  logic        scl_d, sda_d, rise, start;
  logic [3:0]  bit_cnt, next_bit_cnt, byte_cnt, next_byte_cnt;
  logic [6:0]  sh, next_sh;
  logic [15:0] hi_cnt, next_hi_cnt, per_cnt, next_per_cnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Edges seen against the previous sample
  assign rise  = scl & ~scl_d;
  assign start = scl & scl_d & sda_d & ~sda;

  // Slot position, address shift and saturating timers
  always_comb
  begin
    next_bit_cnt  = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_sh       = sh;
    next_hi_cnt   = scl ? hi_cnt + {15'h0000, ~&hi_cnt} : 16'h0000;
    next_per_cnt  = rise ? 16'h0000 : per_cnt + {15'h0000, ~&per_cnt};
    if (start)
    begin
      next_bit_cnt  = 4'h0;
      next_byte_cnt = 4'h0;
    end
    else if (rise)
    begin
      next_sh      = {sh[5:0], sda};
      next_bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt == 4'h8 && byte_cnt != 4'hf)
        next_byte_cnt = byte_cnt + 4'h1;
    end
  end

  // Timers start saturated so idle time before reset never looks short
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      bit_cnt  <= 4'h0;
      byte_cnt <= 4'h0;
      sh       <= 7'h00;
      hi_cnt   <= 16'hffff;
      per_cnt  <= 16'hffff;
    end
    else
    begin
      scl_d    <= scl;
      sda_d    <= sda;
      bit_cnt  <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      sh       <= next_sh;
      hi_cnt   <= next_hi_cnt;
      per_cnt  <= next_per_cnt;
    end
  end

  a_start_hold: assert property ($fell(sda) && scl |-> scl [*8])
    else $error("SCL dropped right after start");
  a_stop_idle: assert property ($rose(sda) && scl |-> (sda && s_sda_oe_n) [*8])
    else $error("Bus not idle after stop");
  a_dev_change_low: assert property ($changed(s_sda_oe_n) |-> !scl)
    else $error("Device moved SDA while SCL high");
  a_dev_hold_high: assert property (rise && !s_sda_oe_n |-> !s_sda_oe_n [*8])
    else $error("Device let go of SDA during high phase");
  a_dev_drive_soon: assert property ($fell(s_sda_oe_n) |-> ##[1:150] rise)
    else $error("No SCL rise after device drove SDA");
  a_scl_period: assert property (rise |-> per_cnt >= 4 * QUARTER - 2)
    else $error("SCL period too short");
  a_scl_high_len: assert property ($fell(scl) |-> hi_cnt >= 2 * QUARTER - 2)
    else $error("SCL high phase too short");
  a_first_addr: assert property (rise && byte_cnt == 4'h0 && bit_cnt == 4'h7 |-> sh == `DEV_ADDR)
    else $error("Wrong slave address sent");
  a_addr_ack: assert property (rise && byte_cnt == 4'h0 && bit_cnt == 4'h8 |-> !sda)
    else $error("Address byte not acknowledged");
  a_host_ack_free: assert property (rise && bit_cnt == 4'h8 |-> m_sda_oe_n)
    else $error("Host pulled SDA in acknowledge slot");
endmodule // mts_link_sva

// [i2c_slave_register_port_bench.sv]
`timescale 1ns/1ps
`include "mts_link_params.svh"
module i2c_slave_register_port_bench;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, irq, wr_pulse;
  logic [4:0]  det = 5'h00;
  logic [55:0] settings, settings_b, exp_set;
  logic [2:0]  wr_index;
  logic [2:0]  last_idx = 3'h0;
  int          error_cnt = 0;
  int          check_count = 0;

  mts_link_if link ();
  mts_link_if link_b ();

  always #25 ref_clk = ~ref_clk;

  mts_link_host #(.QUARTER(50)) u_mts_link_host (.link(link.host), .ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  mts_link_dev u_mts_link_dev (.link(link.device), .ref_clk(ref_clk), .nrst(nrst), .pilot_det(det[4]),
    .sap_det(det[3]), .noise_det(det[2]), .stereo_rx(det[1]), .sap_rx(det[0]), .settings(settings),
    .wr_pulse(wr_pulse), .wr_index(wr_index));
  // Second device faces the bench's own bit-banged master
  mts_link_dev u_mts_link_dev_b (.link(link_b.device), .ref_clk(ref_clk), .nrst(nrst), .pilot_det(det[4]),
    .sap_det(det[3]), .noise_det(det[2]), .stereo_rx(det[1]), .sap_rx(det[0]), .settings(settings_b),
    .wr_pulse(), .wr_index());
  mts_link_sva #(.QUARTER(50)) u_mts_link_sva (.ref_clk(ref_clk), .nrst(nrst), .m_scl_o(link.m_scl_o),
    .m_scl_oe_n(link.m_scl_oe_n), .m_sda_o(link.m_sda_o), .m_sda_oe_n(link.m_sda_oe_n),
    .s_sda_o(link.s_sda_o), .s_sda_oe_n(link.s_sda_oe_n), .scl(link.scl), .sda(link.sda));

  // Remember which register the strobe named
  always @(posedge ref_clk)
    if (wr_pulse === 1'b1)
      last_idx <= wr_index;

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    // No cycle count assumed; only the watchdog ends a hung wait
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Full host transfer, polled until busy drops
  task automatic xfer(input logic rdir, input logic [7:0] sub, input logic [7:0] d);
    bus(1'b1, `OFS_SUBADDR, {24'h0, sub});
    bus(1'b1, `OFS_WDATA, {24'h0, d});
    bus(1'b1, `OFS_CTRL, {30'h0, rdir, 1'b1});
    do
      bus(1'b0, `OFS_STATUS, 32'h0);
    while (rd[0] !== 1'b0);
    repeat (2) @(posedge ref_clk);
  endtask

  // Bit-banged lines: level 1 releases, clock stands high between frames
  task automatic lk(input logic c, input logic d, input int n);
    @(posedge ref_clk);
    link_b.m_scl_oe_n <= c;
    link_b.m_sda_oe_n <= d;
    repeat (n - 1) @(posedge ref_clk);
  endtask

  task automatic cond(input logic stop);
    lk(1'b0, 1'b0, 2);
    lk(1'b1, ~stop, 4);
    lk(1'b1, stop, 8);
    if (!stop)
      lk(1'b0, 1'b0, 2);
  endtask

  // 400 ns bit: data moves only while the clock is low
  task automatic send(input logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      lk(1'b0, b[i], 2);
      lk(1'b1, b[i], 4);
      lk(1'b0, b[i], 2);
    end
    lk(1'b0, 1'b1, 2);
    lk(1'b1, 1'b1, 2);
    check("ack slot", link_b.sda, ack);
    lk(1'b1, 1'b1, 2);
    lk(1'b0, 1'b1, 2);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    link_b.m_scl_o    = 1'b0;
    link_b.m_sda_o    = 1'b0;
    link_b.m_scl_oe_n = 1'b1;
    link_b.m_sda_oe_n = 1'b1;
    exp_set = 56'h0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    check("mute bit", settings[48], 1'b0);
    bus(1'b0, 5'h1c, 32'h0);
    check("unmapped read", rd, 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    // Single writes through the host, interrupt raised and cleared
    for (int i = 0; i < 7; i += 3)
    begin
      exp_set[8*i +: 8] = 8'h5a ^ 8'(i * 37);
      xfer(1'b0, 8'(i), exp_set[8*i +: 8]);
      check("settings", settings, exp_set);
      check("stored index", last_idx, i);
      check("irq raised", irq, 1'b1);
      bus(1'b1, `OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge ref_clk);
      check("irq cleared", irq, 1'b0);
    end
    xfer(1'b0, 8'h07, 8'hc3);
    check("past last register", settings, exp_set);
    // Refused data byte: host must flag the missing acknowledge
    bus(1'b0, `OFS_STATUS, 32'h0);
    check("nack status", rd, 32'h2);
    bus(1'b0, `OFS_IRQ_STAT, 32'h0);
    check("nack event", rd, 32'h3);
    // Status reads; power-on flag reported once, done masked off
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      det <= k ? 5'h09 : 5'h16;
      xfer(1'b1, 8'h00, 8'h00);
      bus(1'b0, `OFS_RDATA, 32'h0);
      check("status byte", rd, {24'h0, k == 0, k ? 5'h09 : 5'h16, 2'h3});
      check("masked irq", irq, 1'b0);
    end
    // Burst of all seven registers from subaddress zero
    cond(1'b0);
    send(8'h8e, 1'b0);
    send(8'h00, 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      exp_set[8*i +: 8] = 8'hf1 - 8'(i * 19);
      send(exp_set[8*i +: 8], 1'b0);
    end
    cond(1'b1);
    check("burst settings", settings_b, exp_set);
    // Foreign address is left unanswered and changes nothing
    cond(1'b0);
    send(8'h90, 1'b1);
    send(8'h00, 1'b1);
    cond(1'b1);
    check("foreign settings", settings_b, exp_set);
    end_sim();
  end
endmodule // i2c_slave_register_port_bench
